// ===== rtl/serial_port_zero_uart.sv
// Serial port zero: control and data registers, transmit and receive engines
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.svh"
// Operation
// - Async frame: start, 8 or 9 data, stop
// - Mode bits select mode; mode 0 12/4 clocks
// - Modes 1 and 3 timed by Timer 1
// - Mode 2 period 64 or 32 clocks
// - Qualifier enables multiprocessor in modes 2, 3
// - Mode 1 flag at the stop bit sample, valid-stop option
// - Receive enable gates reception, starts mode 0
// - Ninth transmit bit sent in modes 2, 3
// - Ninth receive bit holds ninth or stop
// - Transmit flag at end of last data bit
// - Receive flag at end of received byte
// - Data address: write transmits, read receives
module serial_port_zero_uart
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic double_rate_bit,
  input wire logic t1_overflow,
  input wire logic idle_mode,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0] ctrl_q;
  logic ninth_receive_bit_q, transmit_done_flag_q, receive_done_flag_q;
  logic [7:0] rx_buf_q;
  logic rxd_s1_q, rxd_s2_q, rxd_prev_q;
  tx_state_e tx_state_q;
  rx_state_e rx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_bits_q, tx_tick_q, m0_cnt_q, rx_idx_q, rx_tick_q;
  logic m0_rx_q;
  logic [8:0] rx_shift_q;
  logic tick16;
  mode_t mode;
  logic mode_qualifier, rx_enable, ninth_transmit_bit;
  logic wr_ctrl, wr_data, rd_ctrl, rd_data;
  logic [3:0] m0_period;
  logic m0_end, m0_sample, tx_bit_end, tx_done, rx_sample, rx_done, rx_accept, m0_rx_done;

  assign mode = ctrl_q[4:3];
  assign mode_qualifier = ctrl_q[2];
  assign rx_enable = ctrl_q[1];
  assign ninth_transmit_bit = ctrl_q[0];
  assign wr_ctrl = sfr_wr && sfr_addr == `ADDR_CONTROL;
  assign wr_data = sfr_wr && sfr_addr == `ADDR_DATA;
  assign rd_ctrl = sfr_rd && sfr_addr == `ADDR_CONTROL;
  assign rd_data = sfr_rd && sfr_addr == `ADDR_DATA;

  uart_baud_gen uart_baud_gen_i (
    .clk(clk),
    .reset_n(reset_n),
    .mode(mode),
    .double_rate(double_rate_bit),
    .t1_overflow(t1_overflow),
    .idle_mode(idle_mode),
    .tick16(tick16)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign m0_period = mode_qualifier ? `M0_PERIOD_FAST : `M0_PERIOD_SLOW;
  assign m0_end = tx_state_q == TX_SYNC && !idle_mode && m0_cnt_q == m0_period - 4'd1;
  assign m0_sample = tx_state_q == TX_SYNC && !idle_mode && m0_cnt_q == (m0_period >> 1) - 4'd1;
  assign tx_bit_end = tx_state_q == TX_ASYNC && tick16 && tx_tick_q == 4'hf;
  assign tx_done = (tx_bit_end && tx_bits_q == 4'd2) || (m0_end && !m0_rx_q && tx_bits_q == 4'd1);
  assign m0_rx_done = m0_end && m0_rx_q && tx_bits_q == 4'd1;
  assign rx_sample = rx_state_q == RX_BITS && tick16 && rx_tick_q == `MID_SAMPLE;
  assign rx_done = rx_sample && rx_idx_q == `LAST_RX_INDEX;
  assign rx_accept = rx_done && !receive_done_flag_q && (!mode_qualifier || rxd_s2_q);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd_in;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 5'(`CONTROL_RESET >> 3);
      ninth_receive_bit_q <= 1'b0;
      transmit_done_flag_q <= 1'b0;
      receive_done_flag_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= sfr_wdata[`BIT_MODE_HIGH:`BIT_NINTH_TX];
        ninth_receive_bit_q <= sfr_wdata[`BIT_NINTH_RX];
      end
      if (rx_accept) begin
        ninth_receive_bit_q <= rxd_s2_q;
      end
      // Hardware set wins over a software clear
      transmit_done_flag_q <= tx_done || (wr_ctrl ? sfr_wdata[`BIT_TX_DONE] : transmit_done_flag_q);
      receive_done_flag_q <= rx_accept || (m0_rx_done && !receive_done_flag_q) ||
        (wr_ctrl ? sfr_wdata[`BIT_RX_DONE] : receive_done_flag_q);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (rd_ctrl) begin
      sfr_rdata <= {ctrl_q, ninth_receive_bit_q, transmit_done_flag_q, receive_done_flag_q};
    end else if (rd_data) begin
      sfr_rdata <= rx_buf_q;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buf_q <= `DATA_RESET;
    end else if (rx_accept) begin
      rx_buf_q <= rx_shift_q[8:1];
    end else if (m0_rx_done && !receive_done_flag_q) begin
      rx_buf_q <= tx_shift_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit engine, also runs mode 0 in both directions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_tick_q <= 4'h0;
      m0_cnt_q <= 4'h0;
      m0_rx_q <= 1'b0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_tick_q <= 4'h0;
          m0_cnt_q <= 4'h0;
          if (wr_data && mode == 2'd0) begin
            tx_state_q <= TX_SYNC;
            tx_shift_q <= {3'b111, sfr_wdata};
            tx_bits_q <= `SYNC_BITS;
            m0_rx_q <= 1'b0;
          end else if (wr_data) begin
            tx_state_q <= TX_ASYNC;
            tx_shift_q <= {1'b1, mode == 2'd1 ? 1'b1 : ninth_transmit_bit, sfr_wdata, 1'b0};
            tx_bits_q <= mode == 2'd1 ? `FRAME_BITS_M1 : `FRAME_BITS_M23;
          end else if (mode == 2'd0 && rx_enable && !receive_done_flag_q) begin
            tx_state_q <= TX_SYNC;
            tx_shift_q <= 11'h7ff;
            tx_bits_q <= `SYNC_BITS;
            m0_rx_q <= 1'b1;
          end
        end
        TX_ASYNC: begin
          if (tick16) begin
            tx_tick_q <= tx_tick_q + 4'd1;
          end
          if (tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'd1;
            if (tx_bits_q == 4'd1) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        TX_SYNC: begin
          if (!idle_mode) begin
            m0_cnt_q <= m0_end ? 4'h0 : m0_cnt_q + 4'd1;
          end
          if (m0_sample && m0_rx_q) begin
            tx_shift_q <= {3'b111, rxd_s2_q, tx_shift_q[7:1]};
          end
          if (m0_end) begin
            if (!m0_rx_q) begin
              tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            end
            tx_bits_q <= tx_bits_q - 4'd1;
            if (tx_bits_q == 4'd1) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Pin drivers; shift clock low in first half of each mode 0 bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      txd <= tx_state_q == TX_SYNC ? m0_cnt_q >= (m0_period >> 1) :
             tx_state_q == TX_ASYNC ? tx_shift_q[0] : 1'b1;
      rxd_out <= tx_shift_q[0];
      rxd_oe_n <= !(tx_state_q == TX_SYNC && !m0_rx_q);
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receive engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_tick_q <= 4'h0;
      rxd_prev_q <= 1'b1;
    end else begin
      if (tick16) begin
        rxd_prev_q <= rxd_s2_q;
      end
      case (rx_state_q)
        RX_IDLE: begin
          rx_idx_q <= 4'h0;
          rx_tick_q <= 4'h0;
          if (tick16 && mode != 2'd0 && rx_enable && rxd_prev_q && !rxd_s2_q) begin
            rx_state_q <= RX_BITS;
            rx_tick_q <= 4'h1;
          end
        end
        RX_BITS: begin
          if (tick16) begin
            rx_tick_q <= rx_tick_q + 4'd1;
          end
          if (rx_sample) begin
            rx_idx_q <= rx_idx_q + 4'd1;
            if (rx_idx_q == 4'h0 && rxd_s2_q) begin
              rx_state_q <= RX_IDLE;
            end else if (rx_idx_q != 4'h0) begin
              rx_shift_q <= {rxd_s2_q, rx_shift_q[8:1]};
            end
            if (rx_done) begin
              rx_state_q <= RX_IDLE;
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FRAME_LEN: assert property (tx_state_q == TX_IDLE && wr_data && mode != 2'd0 |=>
    tx_bits_q == (mode == 2'd1 ? 4'd10 : 4'd11)) else $error("Async frame length wrong");
  AST_M0_WRAP: assert property (m0_end |=> m0_cnt_q == 4'h0 && $past(m0_cnt_q) ==
    (mode_qualifier ? 4'd3 : 4'd11)) else $error("Mode 0 bit period wrong");
  AST_T1_SOURCE: assert property (mode[0] && $past(mode[0]) && tick16 |-> $past(t1_overflow))
    else $error("Timer 1 not the bit rate source");
  AST_M2_RATE: assert property (mode == 2'd2 && !double_rate_bit && !idle_mode && tick16 ##1
    (mode == 2'd2 && !double_rate_bit && !idle_mode) [*2] |=> !tick16 && !$past(tick16) && !$past(tick16, 2))
    else $error("Mode 2 slow rate wrong");
  AST_MP_FILTER: assert property (rx_done && mode_qualifier && !rxd_s2_q && !receive_done_flag_q
    && !wr_ctrl |=> !receive_done_flag_q) else $error("Data frame raised flag in multiprocessor mode");
  AST_RX_FLAG: assert property (rx_accept |=> receive_done_flag_q && rx_buf_q == $past(rx_shift_q[8:1]))
    else $error("Receive flag or buffer not set");
  AST_RB8: assert property (rx_accept |=> ninth_receive_bit_q == $past(rxd_s2_q))
    else $error("Ninth receive bit not captured");
  AST_REN_GATE: assert property (rx_state_q == RX_IDLE && !rx_enable |=> rx_state_q == RX_IDLE)
    else $error("Reception started while disabled");
  AST_TB8: assert property (tx_state_q == TX_IDLE && wr_data && mode[1] |=>
    tx_shift_q[9] == $past(ninth_transmit_bit)) else $error("Ninth transmit bit not loaded");
  AST_TI_SET: assert property (tx_done |=> transmit_done_flag_q)
    else $error("Transmit flag not set");
  AST_READ_SEP: assert property (rd_data |=> sfr_rdata == $past(rx_buf_q))
    else $error("Data read did not return receive buffer");
  AST_M0_DRIVE: assert property (tx_state_q == TX_SYNC && !m0_rx_q |=> !rxd_oe_n)
    else $error("Mode 0 transmit not driving data");

  COV_ASYNC_TX: cover property (tx_done && mode != 2'd0);
  COV_ASYNC_RX: cover property (rx_accept);
  COV_SYNC_RX: cover property (m0_rx_done);
  COV_MP_REJECT: cover property (rx_done && mode_qualifier && !rxd_s2_q);
endmodule
`default_nettype wire

// ===== rtl/uart_consts.svh
// Register map, field positions and timing counts of serial port zero
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define ADDR_CONTROL 8'h98
`define ADDR_DATA 8'h99
`define CONTROL_RESET 8'h00
`define DATA_RESET 8'h00

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define BIT_MODE_HIGH 7
`define BIT_MODE_LOW 6
`define BIT_QUALIFIER 5
`define BIT_RX_ENABLE 4
`define BIT_NINTH_TX 3
`define BIT_NINTH_RX 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// ----------------------------------------------------------------
// Timing in peripheral clocks, Timer 1 overflows and oversample ticks
// ----------------------------------------------------------------
`define M0_PERIOD_SLOW 4'd12
`define M0_PERIOD_FAST 4'd4
`define M2_PERIOD_SLOW 64
`define M2_PERIOD_FAST 32
`define T1_OVF_PER_BIT_SLOW 32
`define T1_OVF_PER_BIT_FAST 16
`define OVERSAMPLE 16
`define MID_SAMPLE 4'd7
`define M2_DIV_SLOW 3'(`M2_PERIOD_SLOW / `OVERSAMPLE)
`define M2_DIV_FAST 3'(`M2_PERIOD_FAST / `OVERSAMPLE)
`define T1_DIV_SLOW 3'(`T1_OVF_PER_BIT_SLOW / `OVERSAMPLE)
`define T1_DIV_FAST 3'(`T1_OVF_PER_BIT_FAST / `OVERSAMPLE)

// ----------------------------------------------------------------
// Frame lengths in bits
// ----------------------------------------------------------------
`define FRAME_BITS_M1 4'd10
`define FRAME_BITS_M23 4'd11
`define SYNC_BITS 4'd8
`define LAST_RX_INDEX 4'd9

`endif

// ===== rtl/uart_pkg.sv
// Types shared by the serial port zero design
package uart_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC = 3'b100
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_BITS = 2'b10
  } rx_state_e;

  typedef logic [1:0] mode_t;
endpackage

// ===== rtl/uart_baud_gen.sv
// Oversampling tick generator for the asynchronous modes
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.svh"
module uart_baud_gen
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire mode_t mode,
  input wire logic double_rate,
  input wire logic t1_overflow,
  input wire logic idle_mode,
  output logic tick16
);
  logic [2:0] div_q;
  logic [2:0] limit;
  logic step;

  always_comb begin
    if (mode == 2'd2) begin
      limit = double_rate ? `M2_DIV_FAST : `M2_DIV_SLOW;
      step = 1'b1;
    end else begin
      limit = double_rate ? `T1_DIV_FAST : `T1_DIV_SLOW;
      step = t1_overflow;
    end
  end

  // Clock halts in idle, so nothing advances
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 3'h0;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (!idle_mode && step && mode != 2'd0) begin
        if (div_q >= limit - 3'd1) begin
          div_q <= 3'h0;
          tick16 <= 1'b1;
        end else begin
          div_q <= div_q + 3'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/remote_serial_model.sv
// Remote serial transceiver model for serial port zero
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  input wire logic clk,
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe_n,
  output logic rxd_in
);
  logic line_q = 1'b1;
  logic [10:0] got;
  time t0;
  time span;
  // --------------------------------
  // Data pin, follows the model's line_q when released
  // --------------------------------
  assign rxd_in = rxd_oe_n ? line_q : rxd_out;
  // --------------------------------
  // Frame tasks
  // --------------------------------
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line_q <= bits[i];
      repeat (per - 1) @(posedge clk);
    end
    @(posedge clk);
    line_q <= 1'b1;
  endtask
  task automatic take(input int n, input int per);
    got = '1;
    @(negedge txd);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      got[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask
  task automatic take_sync();
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      if (i == 0) begin
        t0 = $time;
        got[8] = rxd_oe_n;
      end
      got[i] = rxd_out;
    end
    span = $time - t0;
  endtask
  task automatic feed_sync(input logic [7:0] v);
    line_q <= v[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txd);
      line_q <= v[i];
    end
    @(posedge txd);
    line_q <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/serial_port_zero_uart_tb_top.sv
// Self-checking testbench for serial port zero
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module serial_port_zero_uart_tb_top
  import uart_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic double_rate_bit = 1'b0;
  logic t1_overflow = 1'b0;
  logic [1:0] t1_div = 2'd0;
  logic idle_mode = 1'b0;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd;
  logic [7:0] rd_q;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // --------------------------------
  // Clock, timer overflow, timeout
  // --------------------------------
  always #50 clk = ~clk;
  // Overflow every third clock, so Timer 1 rates differ from mode 2
  always @(negedge clk) begin
    t1_div <= t1_div == 2'd2 ? 2'd0 : t1_div + 2'd1;
    t1_overflow <= t1_div == 2'd2;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end
  serial_port_zero_uart serial_port_zero_uart_i (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .double_rate_bit(double_rate_bit),
    .t1_overflow(t1_overflow), .idle_mode(idle_mode), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd(txd)
  );
  remote_serial_model remote_serial_model_i (
    .clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .rxd_in(rxd_in)
  );
  // --------------------------------
  // Register access tasks
  // --------------------------------
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    rd_q = sfr_rdata;
    `CHK(nm, e, rd_q)
  endtask
  task automatic tx_case(input logic [7:0] ctl, input logic dbl, input int per, input int n, input logic [7:0] d);
    double_rate_bit = dbl;
    sfr_write(`ADDR_CONTROL, ctl);
    fork
      remote_serial_model_i.take(n, per);
      sfr_write(`ADDR_DATA, d);
    join
    `CHK("tx data", d, remote_serial_model_i.got[8:1])
    `CHK("tx start", 1'b0, remote_serial_model_i.got[0])
    `CHK("tx stop", 1'b1, remote_serial_model_i.got[n - 1])
    if (n == 11) `CHK("tx ninth", ctl[3], remote_serial_model_i.got[9])
    repeat (per) @(negedge clk);
    chk_reg(`ADDR_CONTROL, ctl | 8'h02, "tx flag");
  endtask
  task automatic rx_case(input logic [7:0] ctl, input logic dbl, input int per, input int n, input logic [8:0] d9,
      input logic [7:0] exp_ctl, input logic [7:0] exp_buf);
    double_rate_bit = dbl;
    sfr_write(`ADDR_CONTROL, ctl);
    remote_serial_model_i.send({1'b1, d9, 1'b0}, n, per);
    repeat (8) @(negedge clk);
    chk_reg(`ADDR_CONTROL, exp_ctl, "rx control");
    chk_reg(`ADDR_DATA, exp_buf, "rx buffer");
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    `CHK("txd idle", 1'b1, txd)
    chk_reg(`ADDR_CONTROL, `CONTROL_RESET, "control reset");
    chk_reg(`ADDR_DATA, `DATA_RESET, "data reset");
    sfr_write(8'h9A, 8'hFF);
    chk_reg(8'h9A, 8'h00, "unmapped");
    chk_reg(`ADDR_CONTROL, 8'h00, "control kept");
    sfr_write(`ADDR_CONTROL, 8'hEF);
    chk_reg(`ADDR_CONTROL, 8'hEF, "control readback");
    tx_case(8'h40, 1'b1, 48, 10, 8'hA5);
    tx_case(8'h88, 1'b0, 64, 11, 8'h3C);
    tx_case(8'h80, 1'b1, 32, 11, 8'h5A);
    tx_case(8'hC8, 1'b1, 48, 11, 8'h96);
    tx_case(8'hE0, 1'b0, 96, 11, 8'h01);
    double_rate_bit = 1'b1;
    sfr_write(`ADDR_CONTROL, 8'h80);
    idle_mode = 1'b1;
    sfr_write(`ADDR_DATA, 8'h69);
    repeat (100) @(negedge clk);
    `CHK("idle start held", 1'b0, txd)
    chk_reg(`ADDR_CONTROL, 8'h80, "idle no flag");
    idle_mode = 1'b0;
    repeat (400) @(negedge clk);
    chk_reg(`ADDR_CONTROL, 8'h82, "idle resume flag");
    chk_reg(`ADDR_DATA, 8'h00, "data after writes");
    for (int i = 0; i < 2; i++) begin
      sfr_write(`ADDR_CONTROL, i ? 8'h20 : 8'h00);
      fork
        remote_serial_model_i.take_sync();
        sfr_write(`ADDR_DATA, 8'hC3);
      join
      `CHK("sync tx data", 8'hC3, remote_serial_model_i.got[7:0])
      `CHK("sync drive", 1'b0, remote_serial_model_i.got[8])
      `CHK("sync period", (i ? 4 : 12) * 700, remote_serial_model_i.span)
      repeat (16) @(negedge clk);
      chk_reg(`ADDR_CONTROL, i ? 8'h22 : 8'h02, "sync tx flag");
    end
    fork
      remote_serial_model_i.feed_sync(8'h5A);
      sfr_write(`ADDR_CONTROL, 8'h10);
    join
    repeat (16) @(negedge clk);
    chk_reg(`ADDR_CONTROL, 8'h11, "sync rx flag");
    chk_reg(`ADDR_DATA, 8'h5A, "sync rx data");
    sfr_write(`ADDR_CONTROL, 8'h00);
    rx_case(8'h50, 1'b1, 48, 10, {1'b1, 8'h3C}, 8'h55, 8'h3C);
    rx_case(8'h70, 1'b1, 48, 10, {1'b0, 8'hC4}, 8'h70, 8'h3C);
    rx_case(8'h90, 1'b0, 64, 11, {1'b1, 8'h81}, 8'h95, 8'h81);
    rx_case(8'hB0, 1'b1, 32, 11, {1'b0, 8'h11}, 8'hB0, 8'h81);
    rx_case(8'hF0, 1'b1, 48, 11, {1'b1, 8'h7E}, 8'hF5, 8'h7E);
    rx_case(8'hC0, 1'b1, 48, 11, {1'b1, 8'h22}, 8'hC0, 8'h7E);
    rx_case(8'hD0, 1'b0, 96, 11, {1'b0, 8'h42}, 8'hD1, 8'h42);
    print_verdict();
  end
endmodule
`default_nettype wire
